// ===== rtl/instruction_state_counter.sv
// Sequencer that issues an instruction's cycles and totals their states.
// Assumes a requester holds the instruction fields until done, as the byte count is read after start.
`timescale 1ns/1ps
// Function
// - Total states is the sum over six categories of count times states.
// - On-chip memory cycles cost 2 states; internal cycles cost 1.
// - 8-bit peripheral bus: byte 3 states, word or fetch 6 states.
// - 3-state external access: 3 + m per byte, 6 + 2m word on 8-bit.
// - Memory bit set, clear, invert do two byte cycles; register forms none.
// - Memory bit test does one byte read and no write-back.
// - Multiply costs 12 or 20 internal states; signed 2 fetches, unsigned 1.
// - Divide costs 12 or 20 internal states; signed 2 fetches, unsigned 1.
// - Block move reads and writes n + 1 times, 2n + 2 byte cycles.
// - Block count is the low byte in byte form, full word in word form.
// - Register arithmetic: 16-bit immediate 2 fetches, 32-bit 3, register 1.
// - Long move through memory: 2 word cycles; abs16 3, abs24 4 fetches.
// - Long move with 16-bit displacement performs 2 word cycles.
// - Push and pop: 1 or 2 word cycles plus 2 internal states.
// - 16-bit conditional branch: 2 fetches plus 2 internal, taken or not.
// - Calls and returns: 1 stack cycle normal mode, 2 advanced mode.
module instruction_state_counter
    import state_count_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire op_type op,
    input wire logic memory_operand,
    input wire logic word_size,
    input wire logic long_size,
    input wire addr_type addressing,
    input wire logic advanced_mode,
    input wire logic [15:0] block_count_word,
    input wire target_type code_target,
    input wire target_type data_target,
    input wire target_type stack_target,
    input wire logic periph_bus16,
    input wire logic ext_bus16,
    input wire logic ext_three_state,
    input wire logic [3:0] wait_count,
    output logic busy,
    output logic cycle_valid,
    output cycle_type cycle_kind,
    output logic [7:0] cycle_states,
    output logic done,
    output logic [31:0] total_states
);

    typedef enum logic [2:0] {
        st_idle,
        st_fetch,
        st_branch_addr,
        st_data,
        st_stack,
        st_internal,
        st_finish
    } seq_type;

    seq_type state_q;
    logic [7:0] fetch_c;
    logic [7:0] branch_c;
    logic [7:0] stack_c;
    logic [17:0] byte_c;
    logic [7:0] word_c;
    logic [7:0] internal_c;
    logic [17:0] left_q;
    logic [17:0] left_d;
    logic [7:0] word_left_q;
    logic [7:0] stack_left_q;
    logic [7:0] internal_left_q;
    logic [7:0] branch_left_q;
    logic [31:0] total_q;
    logic [7:0] unit_states;
    cycle_type kind_d;
    target_type target_d;
    logic issue;
    logic done_q;
    logic [7:0] states_q;
    cycle_type kind_q;
    logic valid_q;

    cycle_counts counts (
        .op(op),
        .memory_operand(memory_operand),
        .word_size(word_size),
        .long_size(long_size),
        .addressing(addressing),
        .advanced_mode(advanced_mode),
        .block_count_word(block_count_word),
        .fetch_count(fetch_c),
        .branch_addr_count(branch_c),
        .stack_count(stack_c),
        .byte_count(byte_c),
        .word_count(word_c),
        .internal_count(internal_c)
    );

    state_cost cost (
        .kind(kind_d),
        .target(target_d),
        .periph_bus16(periph_bus16),
        .ext_bus16(ext_bus16),
        .ext_three_state(ext_three_state),
        .wait_count(wait_count),
        .states(unit_states)
    );

    // Cycle kind and bus target for the current state
    always_comb begin
        kind_d = cyc_fetch;
        target_d = code_target;
        issue = 1'b0;
        case (state_q)
            st_fetch: begin
                issue = 1'b1;
            end
            st_branch_addr: begin
                kind_d = cyc_branch_addr;
                issue = 1'b1;
            end
            st_data: begin
                kind_d = (left_q != LEFT_RESET) ? cyc_byte : cyc_word;
                target_d = data_target;
                issue = 1'b1;
            end
            st_stack: begin
                kind_d = cyc_stack;
                target_d = stack_target;
                issue = 1'b1;
            end
            st_internal: begin
                kind_d = cyc_internal;
                issue = 1'b1;
            end
            default: issue = 1'b0;
        endcase
    end

    assign left_d = left_q - 18'h0_0001;

    // Ordered issue: fetch, branch address, data, stack, internal
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= st_idle;
            left_q <= LEFT_RESET;
            word_left_q <= 8'h00;
            stack_left_q <= 8'h00;
            internal_left_q <= 8'h00;
            branch_left_q <= 8'h00;
        end else begin
            case (state_q)
                st_idle: begin
                    if (start) begin
                        left_q <= {10'h000, fetch_c};
                        branch_left_q <= branch_c;
                        word_left_q <= word_c;
                        stack_left_q <= stack_c;
                        internal_left_q <= internal_c;
                        state_q <= st_fetch;
                    end
                end
                st_fetch: begin
                    if (left_q > 18'h0_0001) begin
                        left_q <= left_d;
                    end else if (branch_left_q != 8'h00) begin
                        state_q <= st_branch_addr;
                    end else if (byte_c != 18'h0_0000 || word_left_q != 8'h00) begin
                        left_q <= byte_c;
                        state_q <= st_data;
                    end else if (stack_left_q != 8'h00) begin
                        state_q <= st_stack;
                    end else if (internal_left_q != 8'h00) begin
                        state_q <= st_internal;
                    end else begin
                        state_q <= st_finish;
                    end
                end
                st_branch_addr: begin
                    branch_left_q <= branch_left_q - 8'h01;
                    if (branch_left_q == 8'h01) begin
                        if (byte_c != 18'h0_0000 || word_left_q != 8'h00) begin
                            left_q <= byte_c;
                            state_q <= st_data;
                        end else if (stack_left_q != 8'h00) begin
                            state_q <= st_stack;
                        end else if (internal_left_q != 8'h00) begin
                            state_q <= st_internal;
                        end else begin
                            state_q <= st_finish;
                        end
                    end
                end
                st_data: begin
                    if (left_q != LEFT_RESET) begin
                        left_q <= left_d;
                    end else begin
                        word_left_q <= word_left_q - 8'h01;
                    end
                    if ((left_q == 18'h0_0001 && word_left_q == 8'h00) ||
                        (left_q == LEFT_RESET && word_left_q == 8'h01)) begin
                        if (stack_left_q != 8'h00) begin
                            state_q <= st_stack;
                        end else if (internal_left_q != 8'h00) begin
                            state_q <= st_internal;
                        end else begin
                            state_q <= st_finish;
                        end
                    end
                end
                st_stack: begin
                    stack_left_q <= stack_left_q - 8'h01;
                    if (stack_left_q == 8'h01) begin
                        if (internal_left_q != 8'h00) begin
                            state_q <= st_internal;
                        end else begin
                            state_q <= st_finish;
                        end
                    end
                end
                st_internal: begin
                    internal_left_q <= internal_left_q - 8'h01;
                    if (internal_left_q == 8'h01) begin
                        state_q <= st_finish;
                    end
                end
                st_finish: state_q <= st_idle;
                default: state_q <= st_idle;
            endcase
        end
    end

    // Running sum of states per issued cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            total_q <= TOTAL_RESET;
        end else if (state_q == st_idle && start) begin
            total_q <= TOTAL_RESET;
        end else if (issue) begin
            total_q <= total_q + {24'h00_0000, unit_states};
        end
    end

    // Registered cycle report
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            valid_q <= 1'b0;
            kind_q <= cyc_fetch;
            states_q <= 8'h00;
            done_q <= 1'b0;
        end else begin
            valid_q <= issue;
            kind_q <= kind_d;
            states_q <= issue ? unit_states : 8'h00;
            done_q <= (state_q == st_finish);
        end
    end

    assign busy = (state_q != st_idle);
    assign cycle_valid = valid_q;
    assign cycle_kind = kind_q;
    assign cycle_states = states_q;
    assign done = done_q;
    assign total_states = total_q;

endmodule

// ===== rtl/state_count_pkg.sv
// Constants and types for the instruction state counter.
// Assumes a single 20 MHz clock shared by all users of the package.
package state_count_pkg;

    localparam int CLOCK_HZ = 20000000;
    localparam int CLOCK_NS = 1000000000 / CLOCK_HZ;

    // States per cycle
    localparam logic [7:0] ONCHIP_STATES = 8'h02;
    localparam logic [7:0] INTERNAL_STATES = 8'h01;
    localparam logic [7:0] PERIPH8_BYTE_STATES = 8'h03;
    localparam logic [7:0] PERIPH8_WORD_STATES = 8'h06;
    localparam logic [7:0] PERIPH16_STATES = 8'h03;
    localparam logic [7:0] EXT2_BYTE_STATES = 8'h02;
    localparam logic [7:0] EXT2_WORD8_STATES = 8'h04;
    localparam logic [7:0] EXT3_BYTE_STATES = 8'h03;
    localparam logic [7:0] EXT3_WORD8_STATES = 8'h06;

    // Fixed instruction figures
    localparam logic [7:0] MUL_BYTE_INTERNAL = 8'h0c;
    localparam logic [7:0] MUL_WORD_INTERNAL = 8'h14;
    localparam logic [7:0] PUSH_POP_INTERNAL = 8'h02;
    localparam logic [7:0] BRANCH16_INTERNAL = 8'h02;
    localparam logic [7:0] SIGNED_FETCHES = 8'h02;
    localparam logic [7:0] UNSIGNED_FETCHES = 8'h01;

    // Reset values
    localparam logic [31:0] TOTAL_RESET = 32'h0000_0000;
    localparam logic [17:0] LEFT_RESET = 18'h0_0000;

    typedef enum logic [1:0] {
        target_onchip,
        target_periph,
        target_external
    } target_type;

    typedef enum logic [2:0] {
        cyc_fetch,
        cyc_branch_addr,
        cyc_stack,
        cyc_byte,
        cyc_word,
        cyc_internal
    } cycle_type;

    typedef enum logic [4:0] {
        op_reg_arith,
        op_reg_imm16,
        op_reg_imm32,
        bit_set_op,
        bit_clear_op,
        bit_invert_op,
        bit_test_op,
        signed_multiply_op,
        unsigned_multiply_op,
        signed_divide_op,
        unsigned_divide_op,
        block_move_op,
        long_move_op,
        long_move_disp_op,
        push_op,
        pop_op,
        cond_branch16_op,
        subroutine_jump_op,
        subroutine_branch_op,
        return_op
    } op_type;

    typedef enum logic [1:0] {
        addr_plain,
        addr_abs16,
        addr_abs24
    } addr_type;

endpackage

// ===== rtl/cycle_counts.sv
// Per-instruction cycle counts in the six categories.
// Assumes the sequencer supplies a decoded operation and its options.
`timescale 1ns/1ps
module cycle_counts
    import state_count_pkg::*;
(
    input wire op_type op,
    input wire logic memory_operand,
    input wire logic word_size,
    input wire logic long_size,
    input wire addr_type addressing,
    input wire logic advanced_mode,
    input wire logic [15:0] block_count_word,
    output logic [7:0] fetch_count,
    output logic [7:0] branch_addr_count,
    output logic [7:0] stack_count,
    output logic [17:0] byte_count,
    output logic [7:0] word_count,
    output logic [7:0] internal_count
);

    logic [7:0] block_count_low_byte;
    logic [16:0] moves;

    assign block_count_low_byte = block_count_word[7:0];

    always_comb begin
        // Source and destination each moved n + 1 times
        if (word_size) begin
            moves = {1'b0, block_count_word} + 17'h0_0001;
        end else begin
            moves = {9'h000, block_count_low_byte} + 17'h0_0001;
        end
    end

    always_comb begin
        fetch_count = 8'h01;
        branch_addr_count = 8'h00;
        stack_count = 8'h00;
        byte_count = 18'h0_0000;
        word_count = 8'h00;
        internal_count = 8'h00;
        case (op)
            op_reg_arith: fetch_count = 8'h01;
            op_reg_imm16: fetch_count = 8'h02;
            op_reg_imm32: fetch_count = 8'h03;
            bit_set_op, bit_clear_op, bit_invert_op: begin
                if (memory_operand) begin
                    fetch_count = 8'h02;
                    byte_count = 18'h0_0002;
                end
            end
            bit_test_op: begin
                if (memory_operand) begin
                    fetch_count = 8'h02;
                    byte_count = 18'h0_0001;
                end
            end
            signed_multiply_op, signed_divide_op: begin
                fetch_count = SIGNED_FETCHES;
                internal_count = word_size ? MUL_WORD_INTERNAL :
                    MUL_BYTE_INTERNAL;
            end
            unsigned_multiply_op, unsigned_divide_op: begin
                fetch_count = UNSIGNED_FETCHES;
                internal_count = word_size ? MUL_WORD_INTERNAL :
                    MUL_BYTE_INTERNAL;
            end
            block_move_op: begin
                fetch_count = 8'h02;
                byte_count = {moves, 1'b0};
                internal_count = 8'h04;
            end
            long_move_op: begin
                word_count = 8'h02;
                case (addressing)
                    addr_abs16: fetch_count = 8'h03;
                    addr_abs24: fetch_count = 8'h04;
                    default: fetch_count = 8'h02;
                endcase
            end
            long_move_disp_op: begin
                fetch_count = 8'h03;
                word_count = 8'h02;
            end
            push_op, pop_op: begin
                fetch_count = long_size ? 8'h02 : 8'h01;
                word_count = long_size ? 8'h02 : 8'h01;
                internal_count = PUSH_POP_INTERNAL;
            end
            cond_branch16_op: begin
                fetch_count = 8'h02;
                internal_count = BRANCH16_INTERNAL;
            end
            subroutine_jump_op, subroutine_branch_op, return_op: begin
                fetch_count = 8'h02;
                stack_count = advanced_mode ? 8'h02 : 8'h01;
                internal_count = (op == return_op) ? 8'h02 : 8'h00;
            end
            default: fetch_count = 8'h01;
        endcase
    end

endmodule

// ===== rtl/state_cost.sv
// States for one bus cycle of a given kind and target.
// Assumes the wait count applies only to 3-state external access.
`timescale 1ns/1ps
module state_cost
    import state_count_pkg::*;
(
    input wire cycle_type kind,
    input wire target_type target,
    input wire logic periph_bus16,
    input wire logic ext_bus16,
    input wire logic ext_three_state,
    input wire logic [3:0] wait_count,
    output logic [7:0] states
);

    logic is_byte;
    logic [7:0] m;

    assign is_byte = (kind == cyc_byte);
    assign m = {4'h0, wait_count};

    always_comb begin
        states = ONCHIP_STATES;
        if (kind == cyc_internal) begin
            states = INTERNAL_STATES;
        end else begin
            case (target)
                target_onchip: states = ONCHIP_STATES;
                target_periph: begin
                    if (periph_bus16) begin
                        states = PERIPH16_STATES;
                    end else if (is_byte) begin
                        states = PERIPH8_BYTE_STATES;
                    end else begin
                        states = PERIPH8_WORD_STATES;
                    end
                end
                target_external: begin
                    if (ext_three_state) begin
                        if (ext_bus16 || is_byte) begin
                            states = EXT3_BYTE_STATES + m;
                        end else begin
                            states = EXT3_WORD8_STATES + {m[6:0], 1'b0};
                        end
                    end else if (ext_bus16 || is_byte) begin
                        states = EXT2_BYTE_STATES;
                    end else begin
                        states = EXT2_WORD8_STATES;
                    end
                end
                default: states = ONCHIP_STATES;
            endcase
        end
    end

endmodule

// ===== verif/state_counter_props.sv
// Port checker for the instruction state counter.
// Assumes a bind to the top module and a single clock domain.
`timescale 1ns/1ps
module state_counter_props
    import state_count_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire target_type code_target,
    input wire target_type data_target,
    input wire logic periph_bus16,
    input wire logic ext_bus16,
    input wire logic ext_three_state,
    input wire logic [3:0] wait_count,
    input wire logic busy,
    input wire logic cycle_valid,
    input wire cycle_type cycle_kind,
    input wire logic [7:0] cycle_states,
    input wire logic done,
    input wire logic [31:0] total_states
);
    logic [31:0] sum_q;
    // Sum of reported states since the last accepted start
    always_ff @(posedge clock) begin
        if (!rst_n || (start && !busy)) begin
            sum_q <= 32'h0000_0000;
        end else if (cycle_valid) begin
            sum_q <= sum_q + {24'h00_0000, cycle_states};
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence took_start;
        start && !busy;
    endsequence
    sequence fetch_shown;
        cycle_valid && cycle_kind == cyc_fetch;
    endsequence
    chk_first_fetch: assert property (
        took_start |=> busy ##1 fetch_shown)
        else $error("no fetch two clocks after start");
    chk_idle_states: assert property (
        !cycle_valid |-> cycle_states == 8'h00)
        else $error("states shown without a cycle");
    chk_internal_cost: assert property (
        cycle_valid && cycle_kind == cyc_internal |-> cycle_states == 8'h01)
        else $error("internal cycle not one state");
    chk_onchip_fetch: assert property (
        fetch_shown ##0 code_target == target_onchip |-> cycle_states == 8'h02)
        else $error("on-chip fetch not two states");
    chk_periph_byte: assert property (
        cycle_valid && cycle_kind == cyc_byte && data_target == target_periph
        && !periph_bus16 |-> cycle_states == 8'h03)
        else $error("narrow peripheral byte not three states");
    chk_ext_word: assert property (
        cycle_valid && cycle_kind == cyc_word && data_target == target_external
        && ext_three_state && !ext_bus16
        |-> cycle_states == 8'h06 + {3'h0, wait_count, 1'b0})
        else $error("slow narrow word cost wrong");
    chk_total_sum: assert property (
        done |-> total_states == sum_q)
        else $error("total differs from sum of cycles");
    chk_total_hold: assert property (
        done |=> $stable(total_states))
        else $error("total moved after completion");
    chk_done_pulse: assert property (
        done |=> !done)
        else $error("completion longer than one clock");
endmodule
bind instruction_state_counter state_counter_props u_props (
    .clock(clock), .rst_n(rst_n), .start(start),
    .code_target(code_target), .data_target(data_target),
    .periph_bus16(periph_bus16), .ext_bus16(ext_bus16),
    .ext_three_state(ext_three_state), .wait_count(wait_count),
    .busy(busy), .cycle_valid(cycle_valid), .cycle_kind(cycle_kind),
    .cycle_states(cycle_states), .done(done),
    .total_states(total_states));

// ===== verif/bus_side_model.sv
// Far side model: memory and bus settings seen by the sequencer.
// Assumes requests change only while the sequencer is idle.
`timescale 1ns/1ps
module bus_side_model
    import state_count_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic busy,
    input wire logic [12:0] req_cfg,
    output logic [12:0] cfg
);
    logic [12:0] held_q;
    // Freeze the settings the sequencer took while it runs
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            held_q <= 13'h0000;
        end else if (!busy) begin
            held_q <= req_cfg;
        end
    end
    assign cfg = busy ? held_q : req_cfg;
endmodule

// ===== verif/instruction_state_counter_tb_top.sv
// Self-checking bench for the instruction state counter.
// Assumes the far side model supplies bus settings.
`timescale 1ns/1ps
module instruction_state_counter_tb_top
    import state_count_pkg::*;
    ;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    op_type op = op_reg_arith;
    logic memory_operand = 1'b0;
    logic word_size = 1'b0;
    logic long_size = 1'b0;
    addr_type addressing = addr_plain;
    logic advanced_mode = 1'b0;
    logic [15:0] block_count_word = 16'h0000;
    logic [12:0] rq_cfg = 13'h0000;
    logic [12:0] cfg;
    target_type code_target, data_target, stack_target;
    logic busy, cycle_valid, done;
    cycle_type cycle_kind;
    logic [7:0] cycle_states;
    logic [31:0] total_states;
    int exp_cnt[6], obs_cnt[6], exp_total, acc;
    bit care[6];
    bit care_total;
    int errors = 0;
    int comparisons = 0;
    int ticks = 0;
    assign code_target = target_type'(cfg[12:11]);
    assign data_target = target_type'(cfg[10:9]);
    assign stack_target = target_type'(cfg[8:7]);
    always #25 clock = ~clock;
    bus_side_model far (.clock(clock), .rst_n(rst_n), .busy(busy),
        .req_cfg(rq_cfg), .cfg(cfg));
    instruction_state_counter DUT (
        .clock(clock), .rst_n(rst_n), .start(start), .op(op),
        .memory_operand(memory_operand), .word_size(word_size),
        .long_size(long_size), .addressing(addressing),
        .advanced_mode(advanced_mode), .block_count_word(block_count_word),
        .code_target(code_target), .data_target(data_target),
        .stack_target(stack_target), .periph_bus16(cfg[6]),
        .ext_bus16(cfg[5]), .ext_three_state(cfg[4]),
        .wait_count(cfg[3:0]), .busy(busy), .cycle_valid(cycle_valid),
        .cycle_kind(cycle_kind), .cycle_states(cycle_states),
        .done(done), .total_states(total_states));
    function automatic int cost(cycle_type k);
        int m;
        logic [1:0] t;
        m = int'(rq_cfg[3:0]);
        t = (k == cyc_fetch || k == cyc_branch_addr) ? rq_cfg[12:11] :
            (k == cyc_stack) ? rq_cfg[8:7] : rq_cfg[10:9];
        if (k == cyc_internal) return 1;
        if (t == 2'h0) return 2;
        if (t == 2'h1) return (rq_cfg[6] || k == cyc_byte) ? 3 : 6;
        if (rq_cfg[5] || k == cyc_byte) return rq_cfg[4] ? 3 + m : 2;
        return rq_cfg[4] ? 6 + 2 * m : 4;
    endfunction
    function automatic logic [1:0] rt();
        return 2'($urandom_range(0, 2));
    endfunction
    task automatic check(logic [31:0] got, int want, string what);
        comparisons++;
        if (got !== 32'(want)) begin
            errors++;
            $display("[ERR] %0t %s got %0d want %0d", $time, what, got, want);
        end
    endtask
    task automatic plan_op();
        int n, f, i, l, a;
        n = word_size ? int'(block_count_word) : int'(block_count_word[7:0]);
        f = addressing == addr_abs16 ? 3 : addressing == addr_abs24 ? 4 : 2;
        i = word_size ? 20 : 12;
        l = int'(long_size);
        a = int'(advanced_mode);
        exp_cnt = '{1, 0, 0, 0, 0, 0};
        care = '{1, 1, 1, 1, 1, 1};
        care_total = 1;
        obs_cnt = '{0, 0, 0, 0, 0, 0};
        acc = 0;
        case (op)
            op_reg_imm16: exp_cnt[0] = 2;
            op_reg_imm32: exp_cnt[0] = 3;
            bit_set_op, bit_clear_op, bit_invert_op:
                if (memory_operand) exp_cnt = '{2, 0, 0, 2, 0, 0};
            bit_test_op:
                if (memory_operand) exp_cnt = '{2, 0, 0, 1, 0, 0};
            signed_multiply_op, signed_divide_op:
                exp_cnt = '{2, 0, 0, 0, 0, i};
            unsigned_multiply_op, unsigned_divide_op:
                exp_cnt = '{1, 0, 0, 0, 0, i};
            block_move_op: exp_cnt = '{2, 0, 0, 2 * n + 2, 0, 4};
            long_move_op: exp_cnt = '{f, 0, 0, 0, 2, 0};
            long_move_disp_op: begin
                exp_cnt[4] = 2;
                care[0] = 0;
                care_total = 0;
            end
            push_op, pop_op: exp_cnt = '{1 + l, 0, 0, 0, 1 + l, 2};
            cond_branch16_op: exp_cnt = '{2, 0, 0, 0, 0, 2};
            subroutine_jump_op, subroutine_branch_op: begin
                exp_cnt = '{2, 0, 1 + a, 0, 0, 0};
                care[5] = 0;
                care_total = 0;
            end
            return_op: exp_cnt = '{2, 0, 1 + a, 0, 0, 2};
            default: ;
        endcase
        exp_total = 0;
        for (int k = 0; k < 6; k++) begin
            exp_total += exp_cnt[k] * cost(cycle_type'(k));
        end
    endtask
    task automatic setup(op_type o, logic [5:0] f, logic [15:0] cnt,
            logic [12:0] c);
        op <= o;
        addressing <= addr_type'(f[5:4]);
        {memory_operand, word_size, long_size, advanced_mode} <= f[3:0];
        block_count_word <= cnt;
        rq_cfg <= c;
    endtask
    task automatic run_op(int hold);
        @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        plan_op();
        repeat (hold) @(posedge clock);
        start <= 1'b0;
        for (int k = 0; k < 3000 && done !== 1'b1; k++) @(posedge clock);
        if (done !== 1'b1) begin
            errors++;
            $display("[ERR] %0t no completion", $time);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Per-cycle and per-instruction comparison with the model
    always @(posedge clock) begin
        ticks++;
        if (rst_n && cycle_valid) begin
            check(32'(cycle_states), cost(cycle_kind), "cycle cost");
            obs_cnt[cycle_kind]++;
            acc += int'(cycle_states);
        end
        if (rst_n && done) begin
            for (int k = 0; k < 6; k++) begin
                if (care[k]) check(32'(obs_cnt[k]), exp_cnt[k], "count");
            end
            check(total_states, acc, "running total");
            if (care_total) check(total_states, exp_total, "total");
        end
        if (ticks > 40000) begin
            errors++;
            $display("[ERR] %0t run too long", $time);
            give_verdict();
        end
    end
    initial begin
        void'($urandom(3624));
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        setup(push_op, 6'h02, 16'h0000, 13'h0000);
        run_op(0);
        check(total_states, 10, "push total");
        setup(bit_set_op, 6'h09, 16'h0000, 13'h1331);
        run_op(0);
        check(total_states, 14, "slow bus total");
        setup(block_move_op, 6'h00, 16'h0100, 13'h0000);
        run_op(0);
        check(32'(obs_cnt[3]), 2, "empty move");
        setup(block_move_op, 6'h04, 16'h0100, 13'h0000);
        run_op(0);
        check(32'(obs_cnt[3]), 514, "word move");
        setup(signed_multiply_op, 6'h04, 16'h0000, 13'h0000);
        run_op(4);
        check(total_states, 24, "held start");
        setup(pop_op, 6'h00, 16'h0000, 13'h0413);
        run_op(0);
        check(total_states, 16, "slow word pop");
        for (int r = 0; r < 60; r++) begin
            setup(op_type'(5'(r % 20)),
                {2'($urandom_range(0, 2)), 4'($urandom)},
                16'($urandom & 32'h1ff), {rt(), rt(), rt(), 7'($urandom)});
            run_op(0);
        end
        give_verdict();
    end
endmodule
